// file: sfcfe_pkg.sv
// package of constants and carrier types for the serial flash command front end
`default_nettype none
package sfcfe_pkg;
  // =====================================================================
  // command opcodes
  localparam logic [7:0] OPC_WRITE_ARM = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISARM = 8'h04;
  localparam logic [7:0] OPC_JEDEC_ID_READ = 8'h9f;
  localparam logic [7:0] OPC_STATUS_READ = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST_READ = 8'h0b;
  localparam logic [7:0] OPC_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] OPC_QUAD_IO_READ = 8'heb;

  // =====================================================================
  // field lengths in serial clocks
  localparam logic [4:0] OPCODE_CLKS = 5'h08;
  localparam logic [4:0] BYTE_CLKS = 5'h08;
  localparam logic [4:0] ADDR_CLKS_X1 = 5'h18;
  localparam logic [4:0] ADDR_CLKS_X2 = 5'h0c;
  localparam logic [4:0] ADDR_CLKS_X4 = 5'h06;
  localparam logic [4:0] DUMMY_CLKS_X1 = 5'h08;
  localparam logic [4:0] DUMMY_CLKS_X2 = 5'h04;
  localparam logic [4:0] DUMMY_CLKS_X4 = 5'h06;

  // =====================================================================
  // status register layout and reset values
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ARM_BIT = 1;
  localparam logic [7:0] STAT_WRITABLE_MASK = 8'hfc;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // =====================================================================
  // array address map: 4 KB sectors, 64 KB blocks
  localparam int ADDR_W = 24;
  localparam int SECTOR_SHIFT = 12;
  localparam int BLOCK_SHIFT = 16;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;

  // =====================================================================
  // lane modes and carrier types
  typedef enum logic [1:0] {SFCFE_X1, SFCFE_X2, SFCFE_X4} sfcfe_lanes_e;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } sfcfe_pad_s;

  typedef struct packed {
    logic rd;
    logic [ADDR_W-1:0] addr;
  } sfcfe_mem_req_s;
endpackage
`default_nettype wire

// file: sfcfe_sync.sv
// two-flop synchroniser for pin inputs
`default_nettype none
module sfcfe_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // =====================================================================
  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: sfcfe_addr_map.sv
// array address map: sector and block numbers of an address
`default_nettype none
module sfcfe_addr_map import sfcfe_pkg::*; #(
  parameter int SECTOR_W = 9,
  parameter int BLOCK_W = 5
) (
  input wire logic [ADDR_W-1:0] addr,
  output logic [SECTOR_W-1:0] sector,
  output logic [BLOCK_W-1:0] block
);
  // =====================================================================
  // sixteen 4 KB sectors per 64 KB block, so block 1 starts at 010000h
  always_comb begin
    sector = addr[SECTOR_SHIFT +: SECTOR_W];
    block = addr[BLOCK_SHIFT +: BLOCK_W];
  end
endmodule
`default_nettype wire

// file: sfcfe_core.sv
// serial flash command front end: command decode, read streaming, write latch and status
// Function
// - invalid opcode: standby until next select fall
// - standby keeps all data outputs high-Z
// - valid command: active until select rises
// - sample on clock rise, shift out on fall
// - work in clock mode 0 and 3
// - data-out commands end on any select rise
// - write-type commands need byte-aligned select rise
// - array reads ignored while write busy
// - read: three address bytes; fast adds dummy
// - dual read: address, dummy, data on two
// - quad read: address, dummy, data on four
// - id read: maker byte, two device bytes
// - write-disarm clears write-arm latch
// - status read shifts out; write loads byte
// - 4 KB sectors, 64 KB blocks address map
// - status write needs write-arm latch set
// - latch cleared at reset, disarm, completions
`default_nettype none
module sfcfe_core import sfcfe_pkg::*; #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] TYPE_ID = 8'h3c, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h15 // arbitrary value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io_i,
  output sfcfe_pad_s pad,
  output sfcfe_mem_req_s mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic write_busy,
  input wire logic write_done,
  output logic [7:0] status_q,
  output logic active_q,
  output logic mode3_q,
  output logic [8:0] sector_q,
  output logic [4:0] block_q
);
  typedef enum {ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA_IN, ST_DONE, ST_OUT, ST_STANDBY} sfcfe_state_e;

  sfcfe_state_e state_q;
  logic [5:0] pins_s;
  logic cs_n_s, sclk_s, cs_n_p, sclk_p;
  logic rise, fall, cs_fall, cs_rise;
  logic [7:0] cmd_q, sr_q, out_sr_q, next_q;
  logic [4:0] cnt_q;
  logic [2:0] obit_q;
  logic [1:0] idx_q;
  sfcfe_lanes_e lanes_q;
  logic [ADDR_W-1:0] addr_q;
  logic extra_q, kick_q, rd_pend_q, arm_q;
  logic [7:0] opc_in;
  logic fetch;
  logic [8:0] map_sector;
  logic [4:0] map_block;

  // =====================================================================
  // helper functions
  function automatic logic [4:0] addr_clks(input sfcfe_lanes_e l);
    case (l)
      SFCFE_X2: addr_clks = ADDR_CLKS_X2;
      SFCFE_X4: addr_clks = ADDR_CLKS_X4;
      default: addr_clks = ADDR_CLKS_X1;
    endcase
  endfunction

  function automatic logic [4:0] dummy_clks(input sfcfe_lanes_e l);
    case (l)
      SFCFE_X2: dummy_clks = DUMMY_CLKS_X2;
      SFCFE_X4: dummy_clks = DUMMY_CLKS_X4;
      default: dummy_clks = DUMMY_CLKS_X1;
    endcase
  endfunction

  // last bit slot of a byte at the given lane width
  function automatic logic [2:0] byte_last(input sfcfe_lanes_e l);
    case (l)
      SFCFE_X2: byte_last = 3'h3;
      SFCFE_X4: byte_last = 3'h1;
      default: byte_last = 3'h7;
    endcase
  endfunction

  function automatic logic [7:0] id_byte(input logic [1:0] i);
    case (i)
      2'h0: id_byte = MAKER_ID;
      2'h1: id_byte = TYPE_ID;
      default: id_byte = PART_ID;
    endcase
  endfunction

  function automatic logic is_array_read(input logic [7:0] c);
    is_array_read = (c == OPC_READ) || (c == OPC_FAST_READ) || (c == OPC_DUAL_IO_READ) || (c == OPC_QUAD_IO_READ);
  endfunction

  // =====================================================================
  // pin synchronisation and edge detection
  sfcfe_sync #(.W(6)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({~cs_n, sclk, io_i}), // select goes in inverted so the synced reset value reads as deselected
    .q(pins_s)
  );

  assign cs_n_s = !pins_s[5];
  assign sclk_s = pins_s[4];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_n_p <= 1'b1;
      sclk_p <= 1'b0;
    end else begin
      cs_n_p <= cs_n_s;
      sclk_p <= sclk_s;
    end
  end

  // clock edges only count while selected
  assign rise = !cs_n_s && sclk_s && !sclk_p;
  assign fall = !cs_n_s && !sclk_s && sclk_p;
  assign cs_fall = !cs_n_s && cs_n_p;
  assign cs_rise = cs_n_s && !cs_n_p;
  assign opc_in = {sr_q[6:0], pins_s[0]};
  assign fetch = kick_q || (fall && state_q == ST_OUT && obit_q == 3'h0);

  // =====================================================================
  // mode 0 or mode 3 is taken from the clock level at select fall
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode3_q <= 1'b0;
    end else if (cs_fall) begin
      mode3_q <= sclk_s;
    end
  end

  // =====================================================================
  // command sequencer; in mode 3 the leading fall is harmless as nothing shifts out yet
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cmd_q <= 8'h00;
      sr_q <= 8'h00;
      cnt_q <= 5'h00;
      lanes_q <= SFCFE_X1;
      extra_q <= 1'b0;
      kick_q <= 1'b0;
    end else begin
      kick_q <= 1'b0;
      if (cs_n_s) begin
        state_q <= ST_IDLE;
      end else if (state_q == ST_IDLE) begin
        state_q <= ST_OPCODE;
        cnt_q <= 5'h00;
        extra_q <= 1'b0;
        lanes_q <= SFCFE_X1;
      end else if (rise) begin
        case (state_q)
          ST_OPCODE: begin
            sr_q <= opc_in;
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == OPCODE_CLKS - 5'h01) begin
              cmd_q <= opc_in;
              cnt_q <= 5'h00;
              case (opc_in)
                OPC_WRITE_ARM, OPC_WRITE_DISARM: state_q <= ST_DONE;
                OPC_STATUS_WRITE: state_q <= ST_DATA_IN;
                OPC_JEDEC_ID_READ, OPC_STATUS_READ: begin
                  state_q <= ST_OUT;
                  kick_q <= 1'b1;
                end
                OPC_READ, OPC_FAST_READ: state_q <= write_busy ? ST_STANDBY : ST_ADDR;
                OPC_DUAL_IO_READ: begin
                  state_q <= write_busy ? ST_STANDBY : ST_ADDR;
                  lanes_q <= SFCFE_X2;
                end
                OPC_QUAD_IO_READ: begin
                  state_q <= write_busy ? ST_STANDBY : ST_ADDR;
                  lanes_q <= SFCFE_X4;
                end
                default: state_q <= ST_STANDBY;
              endcase
            end
          end
          ST_ADDR: begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == addr_clks(lanes_q) - 5'h01) begin
              cnt_q <= 5'h00;
              if (cmd_q == OPC_READ) begin
                state_q <= ST_OUT;
                kick_q <= 1'b1;
              end else begin
                state_q <= ST_DUMMY;
              end
            end
          end
          ST_DUMMY: begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == dummy_clks(lanes_q) - 5'h01) begin
              state_q <= ST_OUT;
              kick_q <= 1'b1;
            end
          end
          ST_DATA_IN: begin
            sr_q <= opc_in;
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == BYTE_CLKS - 5'h01) begin
              state_q <= ST_DONE;
            end
          end
          ST_DONE: extra_q <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // =====================================================================
  // address capture over 1, 2 or 4 lanes, then increment per fetched byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= ADDR_RESET;
    end else if (rise && state_q == ST_ADDR) begin
      case (lanes_q)
        SFCFE_X2: addr_q <= {addr_q[ADDR_W-3:0], pins_s[1:0]};
        SFCFE_X4: addr_q <= {addr_q[ADDR_W-5:0], pins_s[3:0]};
        default: addr_q <= {addr_q[ADDR_W-2:0], pins_s[0]};
      endcase
    end else if (fetch && is_array_read(cmd_q)) begin
      addr_q <= addr_q + 24'h000001;
    end
  end

  // =====================================================================
  // prefetch of the next output byte; memory answers one cycle after rd
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_req <= '0;
      rd_pend_q <= 1'b0;
      next_q <= 8'h00;
      idx_q <= 2'h0;
    end else begin
      mem_req.rd <= 1'b0;
      rd_pend_q <= mem_req.rd;
      if (rd_pend_q) begin
        next_q <= mem_rdata;
      end
      if (kick_q) begin
        idx_q <= 2'h0;
      end
      if (fetch) begin
        if (is_array_read(cmd_q)) begin
          mem_req.rd <= 1'b1;
          mem_req.addr <= addr_q;
        end else if (cmd_q == OPC_JEDEC_ID_READ) begin
          next_q <= id_byte(kick_q ? 2'h0 : idx_q);
          idx_q <= (kick_q || idx_q == 2'h2) ? 2'h1 : idx_q + 2'h1;
        end
      end
    end
  end

  // =====================================================================
  // output shifter: bits change on the falling clock edge only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pad <= '0;
      out_sr_q <= 8'h00;
      obit_q <= 3'h0;
    end else if (state_q != ST_OUT || cs_n_s) begin
      pad.oe <= 4'h0;
      obit_q <= 3'h0;
    end else if (fall) begin
      logic [7:0] word;
      word = (obit_q != 3'h0) ? out_sr_q : (cmd_q == OPC_STATUS_READ) ? status_q : next_q;
      obit_q <= (obit_q == byte_last(lanes_q)) ? 3'h0 : obit_q + 3'h1;
      case (lanes_q)
        SFCFE_X2: begin
          pad.o <= {2'h0, word[7:6]};
          pad.oe <= 4'h3;
          out_sr_q <= {word[5:0], 2'h0};
        end
        SFCFE_X4: begin
          pad.o <= word[7:4];
          pad.oe <= 4'hf;
          out_sr_q <= {word[3:0], 4'h0};
        end
        default: begin
          pad.o <= {2'h0, word[7], 1'b0};
          pad.oe <= 4'h2;
          out_sr_q <= {word[6:0], 1'b0};
        end
      endcase
    end
  end

  // =====================================================================
  // write-arm latch and status register, executed at a byte-aligned select rise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arm_q <= 1'b0;
      status_q <= STAT_RESET;
    end else begin
      status_q[STAT_BUSY_BIT] <= write_busy;
      status_q[STAT_ARM_BIT] <= arm_q;
      if (write_done) begin
        arm_q <= 1'b0;
      end
      if (cs_rise && state_q == ST_DONE && !extra_q) begin
        case (cmd_q)
          OPC_WRITE_ARM: arm_q <= 1'b1;
          OPC_WRITE_DISARM: arm_q <= 1'b0;
          OPC_STATUS_WRITE: begin
            if (arm_q && !write_busy) begin
              status_q[7:2] <= sr_q[7:2] & STAT_WRITABLE_MASK[7:2];
              arm_q <= 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // =====================================================================
  // activity flag and sector/block of the read start address
  sfcfe_addr_map #(.SECTOR_W(9), .BLOCK_W(5)) u_map (
    .addr(addr_q),
    .sector(map_sector),
    .block(map_block)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_q <= 1'b0;
      sector_q <= 9'h000;
      block_q <= 5'h00;
    end else begin
      active_q <= !cs_n_s && state_q != ST_IDLE && state_q != ST_OPCODE && state_q != ST_STANDBY;
      if (kick_q && is_array_read(cmd_q)) begin
        sector_q <= map_sector;
        block_q <= map_block;
      end
    end
  end
endmodule
`default_nettype wire

// file: sfcfe_checker.sv
// port checker of the serial flash command front end
`default_nettype none
module sfcfe_checker import sfcfe_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire sfcfe_pad_s pad,
  input wire logic write_done,
  input wire logic [7:0] status_q,
  input wire logic active_q,
  input wire logic mode3_q,
  input wire logic [8:0] sector_q,
  input wire logic [4:0] block_q
);
  // ==========================================================
  // pins are seen raw, so waits leave room for the synchroniser
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_idle_no_drive: assert property (cs_n [*8] |-> pad.oe == 4'h0)
    else $error("data lanes driven while deselected");
  a_idle_inactive: assert property (cs_n [*8] |-> !active_q)
    else $error("active state kept after deselect");
  a_lane_shape: assert property (pad.oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("output lanes in no legal width");
  a_drive_needs_cmd: assert property ($rose(|pad.oe) |-> active_q)
    else $error("output started without an accepted command");
  a_mode_sample: assert property ($fell(cs_n) |-> ##5 mode3_q == sclk)
    else $error("clock mode not taken at select fall");
  a_done_clears: assert property (cs_n [*8] ##0 write_done |-> ##2 !status_q[STAT_ARM_BIT])
    else $error("write arm latch survived completion");
  a_arm_on_rise: assert property ($rose(status_q[STAT_ARM_BIT]) |-> cs_n)
    else $error("write arm latch set before select rise");
  a_map_nest: assert property (block_q == sector_q[8:4])
    else $error("sector not inside its block");
endmodule

bind sfcfe_core sfcfe_checker chk (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .pad(pad),
  .write_done(write_done), .status_q(status_q), .active_q(active_q), .mode3_q(mode3_q),
  .sector_q(sector_q), .block_q(block_q));
`default_nettype wire

// file: sfcfe_host.sv
// host serial controller model: select, serial clock and data lanes
`default_nettype none
module sfcfe_host (
  output logic cs_n,
  output logic sclk,
  output logic [3:0] hd,
  input wire logic [3:0] io_w
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0] rx;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    hd = 4'h0;
    rx = '0;
  end
  // one clock: lanes move on the fall, sampled on the rise
  task automatic tick(input logic [3:0] v, input int ol);
    sclk = 1'b0;
    hd = v;
    #32;
    sclk = 1'b1;
    if (ol == 1) rx = {rx[62:0], io_w[1]};
    else if (ol > 1) rx = (rx << ol) | 64'(io_w & 4'((1 << ol) - 1));
    #32;
  endtask
  // released lanes toggle each clock so a stale level can never pass as data
  task automatic xfer(input bit m3, input logic [7:0] op, input logic [31:0] arg, input int ab,
                      input int al, input int dc, input int nout, input int ol);
    rx = '0;
    sclk = m3;
    #20;
    cs_n = 1'b0;
    #32;
    for (int i = 7; i >= 0; i--) tick({3'h0, op[i]}, 0);
    for (int i = ab - al; i >= 0; i -= al) tick(4'(arg >> i) & 4'((1 << al) - 1), 0);
    repeat (dc) tick(~hd, 0);
    repeat (nout) tick(~hd, ol);
    if (!m3) begin
      sclk = 1'b0;
      #32;
    end
    cs_n = 1'b1;
    hd = ~hd;
    #40;
  endtask
endmodule
`default_nettype wire

// file: tb_serial_flash_command_front_end.sv
// self-checking bench of the serial flash command front end
`default_nettype none
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); \
  end \
end
module tb_serial_flash_command_front_end import sfcfe_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ID_M = 8'h5a; // arbitrary value
  localparam logic [7:0] ID_T = 8'h3c; // arbitrary value
  localparam logic [7:0] ID_P = 8'h15; // arbitrary value
  logic clk, rstn, cs_n, sclk, write_busy, write_done, mode3_q, active_q, oe_seen, act_seen;
  logic [3:0] hd, io_w;
  logic [7:0] mem_rdata, status_q, st_m;
  logic [8:0] sector_q;
  logic [4:0] block_q;
  logic [15:0] lf;
  sfcfe_pad_s pad;
  sfcfe_mem_req_s mem_req;
  int n_mismatch, comparisons, cyc;
  logic [7:0] idq[$] = '{ID_M, ID_T, ID_P};
  logic [7:0] ops[4] = '{OPC_READ, OPC_FAST_READ, OPC_DUAL_IO_READ, OPC_QUAD_IO_READ};
  int als[4] = '{1, 1, 2, 4};
  int dcs[4] = '{0, DUMMY_CLKS_X1, DUMMY_CLKS_X2, DUMMY_CLKS_X4};
  logic [23:0] edges[4] = '{24'h001fff, 24'h00ffff, 24'h0fffff, 24'hffffff};

  // lanes: a driving design wins, else the host level
  assign io_w = (pad.oe & pad.o) | (~pad.oe & hd);
  sfcfe_host host (.cs_n(cs_n), .sclk(sclk), .hd(hd), .io_w(io_w));
  sfcfe_core #(.MAKER_ID(ID_M), .TYPE_ID(ID_T), .PART_ID(ID_P)) uut (.clk(clk), .rstn(rstn),
    .cs_n(cs_n), .sclk(sclk), .io_i(io_w), .pad(pad), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .write_busy(write_busy), .write_done(write_done), .status_q(status_q), .active_q(active_q),
    .mode3_q(mode3_q), .sector_q(sector_q), .block_q(block_q));

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // array content: a cheap hash, so a wrong address shows as wrong data
  function automatic logic [7:0] mb(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ {a[19:16], a[23:20]} ^ 8'h96;
  endfunction
  function automatic logic [63:0] expv(input logic [23:0] a, input int n);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < n; i++) r = {r[55:0], mb(a + 24'(i))};
    return r;
  endfunction

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // array answers one cycle after a fetch; watchdog on the whole run
  always @(posedge clk) begin
    cyc++;
    oe_seen <= oe_seen | (|pad.oe);
    act_seen <= act_seen | active_q;
    if (mem_req.rd) mem_rdata <= #1 mb(mem_req.addr);
    if (cyc == 40000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tb_wait(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // mode-0 command; the status model follows it
  task automatic cmd(input logic [7:0] op, input logic [31:0] arg, input int ab);
    host.xfer(1'b0, op, arg, ab, 1, 0, 0, 0);
    if (op == OPC_WRITE_ARM && ab == 0) st_m[STAT_ARM_BIT] = 1'b1;
    if (op == OPC_WRITE_DISARM && ab == 0) st_m[STAT_ARM_BIT] = 1'b0;
    if (op == OPC_STATUS_WRITE && ab == 8 && st_m[STAT_ARM_BIT]) st_m = arg[7:0] & STAT_WRITABLE_MASK;
    tb_wait(4);
    `CHK(status_q, st_m)
  endtask
  task automatic rd(input bit m3, input logic [7:0] op, input logic [23:0] a, input int al, input int dc);
    host.xfer(m3, op, {8'h00, a}, 24, al, dc, 32 / al, al);
    `CHK(host.rx, expv(a, 4))
    `CHK({block_q, sector_q}, {a[20:16], a[20:12]})
    `CHK(mode3_q, m3)
  endtask

  initial begin
    rstn = 1'b0;
    write_busy = 1'b0;
    write_done = 1'b0;
    mem_rdata = 8'h00;
    oe_seen = 1'b0;
    act_seen = 1'b0;
    st_m = STAT_RESET;
    lf = 16'h8607;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    tb_wait(6);
    `CHK(status_q, STAT_RESET)
    `CHK(pad.oe, 4'h0)
    $display("test reset finished");
    for (int m = 0; m < 2; m++) begin
      host.xfer(m[0], OPC_JEDEC_ID_READ, 0, 0, 1, 0, 32, 1);
      // after the part byte the sequence wraps back to the type byte
      `CHK(host.rx, {32'h0, idq[0], idq[1], idq[2], idq[1]})
      `CHK(act_seen, 1'b1)
    end
    $display("test identification finished");
    lf = step(lf);
    cmd(OPC_WRITE_ARM, 0, 1);
    cmd(OPC_STATUS_WRITE, {16'h0, lf}, 8);
    cmd(OPC_WRITE_ARM, 0, 0);
    host.xfer(1'b0, OPC_STATUS_READ, 0, 0, 1, 0, 16, 1);
    `CHK(host.rx, {48'h0, st_m, st_m})
    cmd(OPC_STATUS_WRITE, {16'h0, lf}, 8);
    cmd(OPC_WRITE_ARM, 0, 0);
    cmd(OPC_WRITE_DISARM, 0, 0);
    cmd(OPC_WRITE_ARM, 0, 0);
    tb_wait(1);
    write_done = 1'b1;
    tb_wait(1);
    write_done = 1'b0;
    st_m[STAT_ARM_BIT] = 1'b0;
    tb_wait(2);
    `CHK(status_q, st_m)
    $display("test status finished");
    // all read kinds at sector, block and map-top edges, then at random starts in mode 3
    for (int j = 0; j < 8; j++) begin
      lf = step(lf);
      rd(j[2], ops[j % 4], j < 4 ? edges[j] : {lf[7:0], lf}, als[j % 4], dcs[j % 4]);
    end
    lf = step(lf);
    host.xfer(1'b1, OPC_READ, {8'h0, lf[7:0], lf}, 24, 1, 0, 3, 1);
    `CHK(host.rx, expv({lf[7:0], lf}, 1) >> 5)
    `CHK(pad.oe, 4'h0)
    $display("test reads finished");
    // unknown opcode hiding write-arm bytes, then a read while a write is busy
    for (int k = 0; k < 2; k++) begin
      tb_wait(1);
      write_busy = k[0];
      oe_seen = 1'b0;
      act_seen = 1'b0;
      host.xfer(1'b0, k ? OPC_READ : 8'hff, 32'h060606, 24, 1, 0, 16, 1);
      `CHK(oe_seen, 1'b0)
      `CHK(act_seen, 1'b0)
      `CHK(status_q, {st_m[7:1], k[0]})
    end
    tb_wait(1);
    write_busy = 1'b0;
    $display("test refusals finished");
    summarize();
  end
endmodule
`default_nettype wire
